//--- rtl/cnmt_cmd_dec.sv
// Decoder that turns a received frame into a one-cycle NMT command pulse.
`timescale 1ns/1ps
module cnmt_cmd_dec (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_valid,
  input wire cnmt_pkg::cnmt_frame_type rx_frame,
  input wire logic [6:0] node_id,
  output cnmt_pkg::cnmt_cmd_type cmd
);
  import cnmt_pkg::*;

  cnmt_cmd_type cmd_r, cmd_nxt;

  // True when the frame is a well-formed NMT command for this node.
  function automatic logic is_for_me(cnmt_frame_type f, logic [6:0] nid);
    logic addr_ok;
    addr_ok = (f.d1 == CNMT_BCAST_ADDR) || (f.d1 == {1'b0, nid});
    is_for_me = (f.id == CNMT_NMT_ID) && (f.dlc == CNMT_NMT_DLC) && addr_ok;
  endfunction

  // Unknown specifiers give no pulse, so they are silently dropped.
  always_comb begin
    cmd_nxt = '0;
    if (rx_valid && is_for_me(rx_frame, node_id)) begin
      case (rx_frame.d0)
        CNMT_CS_START: cmd_nxt.start = 1'b1;
        CNMT_CS_STOP: cmd_nxt.stop = 1'b1;
        CNMT_CS_PREOP: cmd_nxt.preop = 1'b1;
        CNMT_CS_RST_NODE: cmd_nxt.rst_node = 1'b1;
        CNMT_CS_RST_COMM: cmd_nxt.rst_comm = 1'b1;
        default: cmd_nxt = '0;
      endcase
    end
  end

  // Registered so the state machine sees one clean pulse.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  assign cmd = cmd_r;

endmodule

//--- rtl/cnmt_init_timer.sv
// Counter that times the initialization phase after any reset.
`timescale 1ns/1ps
module cnmt_init_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic restart,
  output logic done
);
  import cnmt_pkg::*;

  logic [11:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;

  // Counts from restart to the last cycle, then stops and flags done.
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (restart) begin
      cnt_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == CNMT_INIT_LAST) begin
        run_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r + 12'h001;
      end
    end
  end

  // Starts running out of reset, since power-up is an initialization too.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      run_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  assign done = run_r && (cnt_r == CNMT_INIT_LAST) && !restart;

endmodule

//--- rtl/cnmt_nmt_slave.sv
// Network management state machine of a CANopen slave node.
`timescale 1ns/1ps
module cnmt_nmt_slave (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] node_id,
  input wire logic rx_valid,
  input wire cnmt_pkg::cnmt_frame_type rx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output cnmt_pkg::cnmt_frame_type tx_frame,
  input wire logic fault,
  output logic emcy_req,
  output logic error_state,
  output logic sdo_enable,
  output logic pdo_enable,
  output logic outputs_enable,
  output logic outputs_fault,
  output logic rst_app_pulse,
  output logic rst_comm_pulse,
  output logic node_id_bad,
  output cnmt_pkg::cnmt_state_type nmt_state
);
  import cnmt_pkg::*;

  cnmt_state_type state_r, state_nxt;
  cnmt_cmd_type cmd;
  logic init_done;
  logic restart;
  logic id_ok;
  logic [6:0] id_r, id_nxt;
  logic tx_valid_r, tx_valid_nxt;
  cnmt_frame_type tx_frame_r, tx_frame_nxt;
  logic emcy_r, emcy_nxt;
  logic err_r, err_nxt;
  logic rst_app_r, rst_app_nxt;
  logic rst_comm_r, rst_comm_nxt;
  logic [5:0] out_r, out_nxt;

  // Only node numbers 1 to 63 are accepted; others hold the node in init.
  assign id_ok = (node_id >= CNMT_NODE_MIN) && (node_id <= CNMT_NODE_MAX);

  // Command decoding, including address filtering.
  cnmt_cmd_dec u_dec (
    .clk(clk),
    .reset(reset),
    .rx_valid(rx_valid),
    .rx_frame(rx_frame),
    .node_id(id_r),
    .cmd(cmd)
  );

  // Initialization timer restarted by either reset command.
  // It flags done only once, so a bad node number needs a fresh reset.
  cnmt_init_timer u_init (
    .clk(clk),
    .reset(reset),
    .restart(restart),
    .done(init_done)
  );

  // The single reset cycle restarts the timer, so init is timed afresh.
  assign restart = (state_r == CNMT_ST_RESET);

  // State transitions. Outside stopped, a fault outranks any command in the same cycle,
  // because a node that cannot drive outputs must not go operational.
  always_comb begin
    state_nxt = state_r;
    id_nxt = id_r;
    tx_valid_nxt = tx_valid_r;
    tx_frame_nxt = tx_frame_r;
    emcy_nxt = 1'b0;
    err_nxt = err_r;
    rst_app_nxt = 1'b0;
    rst_comm_nxt = 1'b0;
    // A frame taken by the controller leaves the queue.
    if (tx_valid_r && tx_ready) begin
      tx_valid_nxt = 1'b0;
    end
    case (state_r)
      CNMT_ST_INIT: begin
        // Node number is latched at the end of init, after reset release.
        if (init_done && id_ok) begin
          id_nxt = node_id;
          tx_valid_nxt = 1'b1;
          tx_frame_nxt.id = CNMT_BOOT_BASE + {4'h0, node_id};
          tx_frame_nxt.dlc = CNMT_BOOT_DLC;
          tx_frame_nxt.d0 = CNMT_BOOT_DATA;
          tx_frame_nxt.d1 = '0;
          state_nxt = CNMT_ST_BOOT;
        end
      end
      CNMT_ST_BOOT: begin
        // Pre-operational is entered once the boot-up frame has gone.
        if (tx_valid_r && tx_ready) begin
          state_nxt = CNMT_ST_PREOP;
        end
      end
      CNMT_ST_RESET: begin
        // One cycle here is enough to restart the init timer.
        state_nxt = CNMT_ST_INIT;
      end
      default: begin
        if (fault && (state_r != CNMT_ST_STOP)) begin
          emcy_nxt = 1'b1;
          err_nxt = 1'b1;
          state_nxt = CNMT_ST_PREOP;
        end else if (cmd.rst_node) begin
          rst_app_nxt = 1'b1;
          rst_comm_nxt = 1'b1;
          err_nxt = 1'b0;
          state_nxt = CNMT_ST_RESET;
        end else if (cmd.rst_comm) begin
          rst_comm_nxt = 1'b1;
          err_nxt = 1'b0;
          state_nxt = CNMT_ST_RESET;
        end else if (cmd.start) begin
          state_nxt = CNMT_ST_OPER;
        end else if (cmd.preop) begin
          state_nxt = CNMT_ST_PREOP;
        end else if (cmd.stop) begin
          state_nxt = CNMT_ST_STOP;
        end
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= CNMT_ST_INIT;
      id_r <= '0;
      tx_valid_r <= 1'b0;
      tx_frame_r <= '0;
      emcy_r <= 1'b0;
      err_r <= 1'b0;
      rst_app_r <= 1'b0;
      rst_comm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      id_r <= id_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_frame_r <= tx_frame_nxt;
      emcy_r <= emcy_nxt;
      err_r <= err_nxt;
      rst_app_r <= rst_app_nxt;
      rst_comm_r <= rst_comm_nxt;
    end
  end

  // Service gates follow the next state so they change with it.
  // Bits: sdo, pdo, outputs enable, outputs fault, unused pair.
  always_comb begin
    out_nxt = '0;
    case (state_nxt)
      CNMT_ST_PREOP: out_nxt = 6'b10_0000;
      CNMT_ST_OPER: out_nxt = 6'b11_1000;
      CNMT_ST_STOP: out_nxt = 6'b00_0100;
      default: out_nxt = '0;
    endcase
  end

  // Gate registers; outputs are safe until the node is configured.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // Ports are plain copies of the registers above, except node_id_bad, decoded from node_id.
  assign sdo_enable = out_r[5];
  assign pdo_enable = out_r[4];
  assign outputs_enable = out_r[3];
  assign outputs_fault = out_r[2];
  assign tx_valid = tx_valid_r;
  assign tx_frame = tx_frame_r;
  assign emcy_req = emcy_r;
  assign error_state = err_r;
  assign rst_app_pulse = rst_app_r;
  assign rst_comm_pulse = rst_comm_r;
  assign node_id_bad = !id_ok;
  assign nmt_state = state_r;

  // A boot-up frame taken by the controller ends the boot phase.
  sequence s_boot_sent;
    tx_valid && tx_ready && (state_r == CNMT_ST_BOOT);
  endsequence

  a_boot_to_preop: assert property (@(posedge clk) disable iff (reset)
    s_boot_sent |=> (state_r == CNMT_ST_PREOP))
    else $error("Boot-up did not lead to pre-operational.");

  a_preop_gates: assert property (@(posedge clk) disable iff (reset)
    (state_r == CNMT_ST_PREOP) && $stable(state_r)
      |-> sdo_enable && !pdo_enable)
    else $error("Pre-operational gating wrong.");

  a_oper_gates: assert property (@(posedge clk) disable iff (reset)
    (state_r == CNMT_ST_OPER) |-> sdo_enable && pdo_enable)
    else $error("Operational gating wrong.");

  a_fault_react: assert property (@(posedge clk) disable iff (reset)
    fault && (state_r == CNMT_ST_OPER)
      |=> emcy_req && error_state && (state_r == CNMT_ST_PREOP))
    else $error("Fault reaction missing.");

  a_stop_outputs: assert property (@(posedge clk)
    disable iff (reset)
    (state_r == CNMT_ST_STOP) |-> outputs_fault && !sdo_enable
      && !pdo_enable && !outputs_enable)
    else $error("Stopped state gating wrong.");

  a_start_cmd: assert property (@(posedge clk) disable iff (reset)
    cmd.start && !fault && !cmd.rst_node && !cmd.rst_comm
      && (state_r == CNMT_ST_PREOP) |=> (state_r == CNMT_ST_OPER)
      && outputs_enable)
    else $error("Start command not obeyed.");

  a_preop_cmd: assert property (@(posedge clk) disable iff (reset)
    cmd.preop && !cmd.start && !fault && (state_r == CNMT_ST_OPER)
      |=> !pdo_enable && sdo_enable)
    else $error("Pre-operational command not obeyed.");

  a_node_reset: assert property (@(posedge clk) disable iff (reset)
    cmd.rst_node && !fault && (state_r == CNMT_ST_STOP)
      |=> rst_app_pulse && rst_comm_pulse ##1 (state_r == CNMT_ST_INIT))
    else $error("Node reset not performed.");

  a_comm_reset: assert property (@(posedge clk) disable iff (reset)
    cmd.rst_comm && !cmd.rst_node && !fault
      && ((state_r == CNMT_ST_PREOP) || (state_r == CNMT_ST_STOP))
      |=> rst_comm_pulse && !rst_app_pulse)
    else $error("Communication reset not performed.");

  a_boot_frame: assert property (@(posedge clk) disable iff (reset)
    $rose(tx_valid) && (state_r == CNMT_ST_BOOT) |-> (tx_frame.dlc
      == CNMT_BOOT_DLC) && (tx_frame.d0 == CNMT_BOOT_DATA)
      && (tx_frame.id == CNMT_BOOT_BASE + {4'h0, id_r}))
    else $error("Boot-up frame malformed.");

  a_node_range: assert property (@(posedge clk) disable iff (reset)
    (state_r == CNMT_ST_PREOP) |-> (id_r >= CNMT_NODE_MIN)
      && (id_r <= CNMT_NODE_MAX))
    else $error("Node number out of range.");

  // A pending boot-up frame must neither drop nor change while the
  // controller is busy, or a torn frame could reach the bus.
  sequence s_boot_pending;
    tx_valid && !tx_ready;
  endsequence

  a_boot_holds: assert property (@(posedge clk) disable iff (reset)
    s_boot_pending |=> tx_valid && $stable(tx_frame))
    else $error("Boot-up frame dropped or changed while pending.");

  // An emergency request is only ever the answer to a fault.
  a_emcy_cause: assert property (@(posedge clk) disable iff (reset)
    emcy_req |-> $past(fault))
    else $error("Emergency request without a fault.");

  // The timer flags done once only, so a bad number means a fresh reset.
  a_bad_node_init: assert property (@(posedge clk) disable iff (reset)
    node_id_bad && (state_r == CNMT_ST_INIT) |=> (state_r == CNMT_ST_INIT))
    else $error("Node left init with a bad node number.");

  // Stopped is left only on a command; a fault there raises no emergency.
  a_stop_holds: assert property (@(posedge clk) disable iff (reset)
    (state_r == CNMT_ST_STOP) && (cmd == '0)
      |=> (state_r == CNMT_ST_STOP) && !emcy_req)
    else $error("Stopped node moved without a command.");

  // Either reset command passes through one reset cycle back to init,
  // with every gate shut, so the node reboots from a safe state.
  sequence s_reset_taken;
    rst_comm_pulse && (state_r == CNMT_ST_RESET);
  endsequence

  sequence s_reboot;
    (state_r == CNMT_ST_INIT) && !tx_valid && (out_r == '0);
  endsequence

  a_reset_reboot: assert property (@(posedge clk) disable iff (reset)
    s_reset_taken |=> s_reboot)
    else $error("Reset command did not return to init.");

endmodule

//--- rtl/cnmt_pkg.sv
// Package of constants and types for the CANopen NMT slave state machine.
package cnmt_pkg;

  // NMT command frame layout.
  localparam logic [10:0] CNMT_NMT_ID = 11'h000;
  localparam logic [3:0] CNMT_NMT_DLC = 4'h2;
  localparam logic [7:0] CNMT_BCAST_ADDR = 8'h00;

  // Command specifiers.
  localparam logic [7:0] CNMT_CS_START = 8'h01;
  localparam logic [7:0] CNMT_CS_STOP = 8'h02;
  localparam logic [7:0] CNMT_CS_PREOP = 8'h80;
  localparam logic [7:0] CNMT_CS_RST_NODE = 8'h81;
  localparam logic [7:0] CNMT_CS_RST_COMM = 8'h82;

  // Boot-up frame.
  localparam logic [10:0] CNMT_BOOT_BASE = 11'h700;
  localparam logic [3:0] CNMT_BOOT_DLC = 4'h1;
  localparam logic [7:0] CNMT_BOOT_DATA = 8'h00;

  // Valid node numbers.
  localparam logic [6:0] CNMT_NODE_MIN = 7'h01;
  localparam logic [6:0] CNMT_NODE_MAX = 7'h3F;

  // Communication object range cleared by a communication reset.
  localparam logic [15:0] CNMT_COMM_LO = 16'h1000;
  localparam logic [15:0] CNMT_COMM_HI = 16'h1FFF;

  // Initialization time and derived cycle count at 10 MHz.
  localparam int CNMT_CLK_HZ = 10_000_000;
  localparam int CNMT_INIT_US = 100;
  localparam int CNMT_INIT_CYC = (CNMT_INIT_US * (CNMT_CLK_HZ / 1_000_000));
  localparam logic [11:0] CNMT_INIT_LAST = 12'(CNMT_INIT_CYC - 1);

  // One-hot NMT states.
  typedef enum logic [5:0] {
    CNMT_ST_INIT = 6'b00_0001,
    CNMT_ST_BOOT = 6'b00_0010,
    CNMT_ST_PREOP = 6'b00_0100,
    CNMT_ST_OPER = 6'b00_1000,
    CNMT_ST_STOP = 6'b01_0000,
    CNMT_ST_RESET = 6'b10_0000
  } cnmt_state_type;

  // Received or transmitted CAN frame, first two data bytes.
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [7:0] d0;
    logic [7:0] d1;
  } cnmt_frame_type;

  // Decoded NMT command.
  typedef struct packed {
    logic start;
    logic stop;
    logic preop;
    logic rst_node;
    logic rst_comm;
  } cnmt_cmd_type;

endpackage

//--- sim/cnmt_master_model.sv
// Model of the CAN controller and NMT master facing the slave machine.
`timescale 1ns/1ps
module cnmt_master_model (
  input wire logic clk,
  input wire logic tx_valid,
  input wire cnmt_pkg::cnmt_frame_type tx_frame,
  output logic rx_valid,
  output cnmt_pkg::cnmt_frame_type rx_frame,
  output logic tx_ready
);
  import cnmt_pkg::*;
  int stall = 0;
  int wait_cnt = 0;
  int tx_count = 0;
  cnmt_frame_type last_tx = '0;

  // Quiet bus at time zero.
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b0;
  end

  // One received frame, valid for exactly one cycle.
  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
    input logic [7:0] cs, input logic [7:0] adr);
    @(negedge clk);
    rx_frame = '{id: id, dlc: dlc, d0: cs, d1: adr};
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    // Stale contents are inverted so a late sample cannot pass by chance.
    rx_frame = ~rx_frame;
  endtask

  // Transmit acceptance after a programmable stall, like a busy bus.
  always @(negedge clk) begin
    if (tx_ready) begin
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid) begin
      if (wait_cnt >= stall) begin
        tx_ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end

  // Capture each frame that the slave hands over.
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      last_tx <= tx_frame;
      tx_count <= tx_count + 1;
    end
  end
endmodule

//--- sim/testbench.sv
// Self-checking testbench for the NMT slave state machine.
`timescale 1ns/1ps
module testbench;
  import cnmt_pkg::*;
  localparam logic [6:0] NODE = 7'h11;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] node_id = NODE;
  logic fault = 1'b0;
  logic rx_valid, tx_valid, tx_ready, emcy_req, error_state, sdo_enable;
  logic pdo_enable, outputs_enable, outputs_fault, rst_app_pulse;
  logic rst_comm_pulse, node_id_bad;
  cnmt_frame_type rx_frame, tx_frame;
  cnmt_state_type nmt_state;
  int error_cnt = 0;
  int checks_done = 0;

  cnmt_nmt_slave cnmt_nmt_slave_inst (
    .clk(clk), .reset(reset), .node_id(node_id), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_frame(tx_frame), .fault(fault), .emcy_req(emcy_req),
    .error_state(error_state), .sdo_enable(sdo_enable),
    .pdo_enable(pdo_enable), .outputs_enable(outputs_enable),
    .outputs_fault(outputs_fault), .rst_app_pulse(rst_app_pulse),
    .rst_comm_pulse(rst_comm_pulse), .node_id_bad(node_id_bad),
    .nmt_state(nmt_state)
  );

  cnmt_master_model model_inst (
    .clk(clk), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_ready(tx_ready)
  );

  // Clock of 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // State plus the gates implied by pre-operational, operational or stopped; other states get no gate check.
  task automatic chk_state(input cnmt_state_type st);
    chk(nmt_state, st);
    case (st)
      CNMT_ST_PREOP: chk({sdo_enable, pdo_enable}, 2'h2);
      CNMT_ST_OPER: chk({sdo_enable, pdo_enable, outputs_enable,
        outputs_fault}, 4'hE);
      CNMT_ST_STOP: chk({sdo_enable, pdo_enable, outputs_enable,
        outputs_fault}, 4'h1);
      default: ;
    endcase
  endtask

  // Waits out init, lets the far side stall, then checks the boot-up frame.
  task automatic boot_seq(input int stall);
    int n = 0;
    int c0;
    c0 = model_inst.tx_count;
    model_inst.stall = stall;
    while (tx_valid !== 1'b1 && n < 1200) begin
      @(negedge clk);
      n++;
    end
    chk(nmt_state, CNMT_ST_BOOT);
    while (nmt_state === CNMT_ST_BOOT || tx_valid === 1'b1) begin
      if (n > 1300) break;
      @(negedge clk);
      n++;
    end
    chk(model_inst.last_tx, {CNMT_BOOT_BASE + 11'(NODE), CNMT_BOOT_DLC,
      CNMT_BOOT_DATA, 8'h00});
    chk(model_inst.tx_count, c0 + 1);
    chk_state(CNMT_ST_PREOP);
    $display("test boot done");
  endtask

  task automatic cmd(input logic [10:0] id, input logic [3:0] dlc,
    input logic [7:0] cs, input logic [7:0] adr, input cnmt_state_type st);
    model_inst.send(id, dlc, cs, adr);
    repeat (2) @(negedge clk);
    chk_state(st);
  endtask

  task automatic nmt(input logic [7:0] cs, input logic [7:0] adr,
    input cnmt_state_type st);
    cmd(CNMT_NMT_ID, CNMT_NMT_DLC, cs, adr, st);
  endtask

  task automatic t_cmds;
    nmt(CNMT_CS_START, 8'(NODE), CNMT_ST_OPER);
    nmt(CNMT_CS_PREOP, CNMT_BCAST_ADDR, CNMT_ST_PREOP);
    nmt(CNMT_CS_START, CNMT_BCAST_ADDR, CNMT_ST_OPER);
    nmt(CNMT_CS_STOP, 8'(NODE), CNMT_ST_STOP);
    cmd(11'h201, 4'h2, CNMT_CS_PREOP, 8'(NODE), CNMT_ST_STOP);
    nmt(CNMT_CS_PREOP, 8'(NODE), CNMT_ST_PREOP);
    $display("test commands done");
  endtask

  task automatic t_ignore;
    nmt(CNMT_CS_START, 8'(NODE + 7'h01), CNMT_ST_PREOP);
    cmd(11'h001, CNMT_NMT_DLC, CNMT_CS_START, 8'(NODE), CNMT_ST_PREOP);
    cmd(CNMT_NMT_ID, 4'h3, CNMT_CS_START, 8'(NODE), CNMT_ST_PREOP);
    nmt(8'h03, 8'(NODE), CNMT_ST_PREOP);
    $display("test ignore done");
  endtask

  task automatic t_fault;
    int n = 0;
    nmt(CNMT_CS_START, 8'(NODE), CNMT_ST_OPER);
    fault = 1'b1;
    while (emcy_req !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk({emcy_req, error_state}, 2'h3);
    chk_state(CNMT_ST_PREOP);
    fault = 1'b0;
    @(negedge clk);
    chk(emcy_req, 1'b0);
    $display("test fault done");
  endtask

  // Reset commands pulse their strobes, clear the error and reboot.
  task automatic t_reset(input logic [7:0] cs);
    model_inst.send(CNMT_NMT_ID, CNMT_NMT_DLC, cs, CNMT_BCAST_ADDR);
    // The reset state lasts one cycle, so it is seen on the first edge.
    @(negedge clk);
    chk(nmt_state, CNMT_ST_RESET);
    chk({rst_app_pulse, rst_comm_pulse},
      {cs == CNMT_CS_RST_NODE, 1'b1});
    @(negedge clk);
    chk({rst_app_pulse, rst_comm_pulse, error_state}, 3'h0);
    chk(nmt_state, CNMT_ST_INIT);
    boot_seq(3);
    $display("test reset done");
  endtask

  task automatic t_node;
    node_id = 7'h00;
    @(negedge clk);
    chk(node_id_bad, 1'b1);
    node_id = 7'h40;
    @(negedge clk);
    chk(node_id_bad, 1'b1);
    node_id = 7'h3F;
    @(negedge clk);
    chk(node_id_bad, 1'b0);
    node_id = NODE;
    $display("test node number done");
  endtask

  // A mid-run reset with a bad node number must give no boot-up.
  task automatic t_badnode;
    @(negedge clk);
    node_id = 7'h00;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (1100) @(negedge clk);
    chk({nmt_state, tx_valid}, {CNMT_ST_INIT, 1'b0});
    node_id = NODE;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    boot_seq(0);
    $display("test bad node done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence; reset released on a falling edge.
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    boot_seq(0);
    t_cmds();
    t_ignore();
    t_fault();
    t_reset(CNMT_CS_RST_COMM);
    nmt(CNMT_CS_STOP, 8'(NODE), CNMT_ST_STOP);
    t_reset(CNMT_CS_RST_NODE);
    t_node();
    t_badnode();
    wrap_up();
  end

  // The whole run takes about 5200 cycles, so this leaves a wide margin.
  initial begin
    #(20_000 * 100);
    error_cnt++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
